/* power_trim_pkg.sv */
package power_trim_pkg;

    // ****************************************************************
    // Register indices (byte address = index * 4)
    // ****************************************************************
    localparam logic [5:0] IDX_LIMIT_SET       = 6'h08;
    localparam logic [5:0] IDX_LIMIT_STAT      = 6'h09;
    localparam logic [5:0] IDX_BOFS_SET        = 6'h20;
    localparam logic [5:0] IDX_BOFS_STAT       = 6'h21;
    localparam logic [5:0] IDX_EOFS_SET        = 6'h22;
    localparam logic [5:0] IDX_EOFS_STAT       = 6'h23;
    localparam logic [5:0] IDX_BSLP_SET        = 6'h24;
    localparam logic [5:0] IDX_BSLP_STAT       = 6'h25;
    localparam logic [5:0] IDX_ESLP_SET        = 6'h26;
    localparam logic [5:0] IDX_ESLP_STAT       = 6'h27;
    localparam logic [5:0] IDX_IRQ_STATUS      = 6'h30;
    localparam logic [5:0] IDX_IRQ_MASK        = 6'h31;

    // ****************************************************************
    // Reset values and writable masks
    // ****************************************************************
    localparam logic [7:0] RST_LIMIT_SET       = 8'h11;
    localparam logic [7:0] RST_OFS_SET         = 8'h00;
    localparam logic [7:0] RST_SLP_SET         = 8'h07;
    localparam logic [7:0] RST_STAT            = 8'h00;
    localparam logic [4:0] RST_IRQ             = 5'h00;
    localparam logic [7:0] WMASK_LIMIT         = 8'hBF;
    localparam logic [7:0] WMASK_OFS           = 8'hDF;
    localparam logic [7:0] WMASK_SLP           = 8'hBF;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int OVERRIDE_BIT   = 7;
    localparam int SHORT_BIT      = 7;
    localparam int SIGN_BIT       = 6;
    localparam int LIM_OPEN_BIT   = 3;
    localparam int TRIM_OPEN_BIT  = 2;

    // ****************************************************************
    // Scaling constants
    // ****************************************************************
    localparam logic [10:0] LIMIT_BASE_MA      = 11'd250;
    localparam logic [10:0] LIMIT_STEP_MA      = 11'd50;
    localparam logic [10:0] SLOPE_BASE_MILLI   = 11'd1038;
    localparam logic [10:0] SLOPE_STEP_MILLI   = 11'd16;
    localparam logic [26:0] SLOPE_SCALE        = 27'd1000;
    localparam logic [10:0] OFS_STEP_MW        = 11'd32;
    localparam logic [3:0]  CODE_SHORTED       = 4'hF;
    localparam logic [3:0]  CODE_OPEN          = 4'h0;
    localparam logic [1:0]  RESP_OKAY          = 2'b00;
    localparam logic [1:0]  RESP_SLVERR        = 2'b10;

    // Interrupt event bit order
    localparam int EV_LIMIT = 0;
    localparam int EV_BOFS  = 1;
    localparam int EV_EOFS  = 2;
    localparam int EV_BSLP  = 3;
    localparam int EV_ESLP  = 4;

    typedef struct packed {
        logic       shorted;
        logic       open;
        logic       in_range;
        logic [2:0] code;
    } limit_strap_t;

    typedef struct packed {
        logic       shorted;
        logic       open;
        logic [3:0] code;
    } trim_strap_t;

endpackage : power_trim_pkg

/* power_trim_config_select.sv */
`timescale 1ns/1ps
// Behaviour
// - Limit from strap unless override bit set or limit pin open
// - Limit register code counts 50 mA steps
// - Limit pin short: flag, end-transfer or end-charge
// - Status shows strap limit, zero out of range
// - Open limit pin flagged, register limit used
// - Power equals slope times function plus offset
// - Basic or extended trims follow power profile
// - Shorted offset pin requests end-transfer
// - Shorted slope pin requests end-transfer
// - Trim register used when open or overridden
// - Trim decoded code forced F shorted, 0 open
// - Basic offset codes: -64, -32, then +32 steps
// - Extended offset codes: -96, -32, then +64 steps
// - Slope 1.054 at code 1, +0.016 per code
// - Trim status bit 2 flags open pin
// - Offset sign bit subtracts when set
// - Offset register magnitude is 32 mW per code
module power_trim_config_select
    import power_trim_pkg::*;
(
    input  wire logic               I_CLK,
    input  wire logic               I_RESET,
    input  wire logic [7:0]         I_AXI_AWADDR,
    input  wire logic               I_AXI_AWVALID,
    output logic                    O_AXI_AWREADY,
    input  wire logic [31:0]        I_AXI_WDATA,
    input  wire logic [3:0]         I_AXI_WSTRB,
    input  wire logic               I_AXI_WVALID,
    output logic                    O_AXI_WREADY,
    output logic [1:0]              O_AXI_BRESP,
    output logic                    O_AXI_BVALID,
    input  wire logic               I_AXI_BREADY,
    input  wire logic [7:0]         I_AXI_ARADDR,
    input  wire logic               I_AXI_ARVALID,
    output logic                    O_AXI_ARREADY,
    output logic [31:0]             O_AXI_RDATA,
    output logic [1:0]              O_AXI_RRESP,
    output logic                    O_AXI_RVALID,
    input  wire logic               I_AXI_RREADY,
    input  wire limit_strap_t       I_EXT_LIMIT_STRAP,
    input  wire trim_strap_t        I_BASIC_OFFSET_STRAP,
    input  wire trim_strap_t        I_EXT_OFFSET_STRAP,
    input  wire trim_strap_t        I_BASIC_SLOPE_STRAP,
    input  wire trim_strap_t        I_EXT_SLOPE_STRAP,
    input  wire logic               I_EXT_PROFILE,
    input  wire logic               I_PMA_MODE,
    input  wire logic [15:0]        I_POWER_FUNC,
    output logic [10:0]             O_CURRENT_LIMIT_MA,
    output logic signed [19:0]      O_RX_POWER_MW,
    output logic                    O_END_TRANSFER_REQ,
    output logic                    O_END_CHARGE_REQ,
    output logic                    O_IRQ
);

    // ****************************************************************
    // Decode functions
    // ****************************************************************
    function automatic logic [10:0] strap_limit_ma(input logic [2:0] code);
        case (code)
            3'h0:    strap_limit_ma = 11'd500;
            3'h1:    strap_limit_ma = 11'd700;
            3'h2:    strap_limit_ma = 11'd900;
            3'h3:    strap_limit_ma = 11'd1000;
            3'h4:    strap_limit_ma = 11'd1100;
            3'h6:    strap_limit_ma = 11'd1300;
            3'h7:    strap_limit_ma = 11'd1500;
            default: strap_limit_ma = 11'd500;
        endcase
    endfunction : strap_limit_ma

    // Status byte: short, forced code, open flag
    function automatic logic [7:0] trim_status(input trim_strap_t s);
        logic [3:0] c;
        c = s.shorted ? CODE_SHORTED : (s.open ? CODE_OPEN : s.code);
        trim_status = {s.shorted, c, s.open, 2'b00};
    endfunction : trim_status

    function automatic logic signed [19:0] strap_offset_mw(input logic [3:0] code, input logic ext);
        logic [10:0] step;
        step = ext ? (OFS_STEP_MW << 1) : OFS_STEP_MW;
        case (code)
            4'h1:    strap_offset_mw = ext ? -20'sd96 : -20'sd64;
            4'h2:    strap_offset_mw = -20'sd32;
            default: strap_offset_mw = $signed({9'h000, OFS_STEP_MW})
                                       + $signed(20'(step * 11'(code - 4'h3)));
        endcase
    endfunction : strap_offset_mw

    function automatic logic [10:0] slope_milli(input logic [5:0] code);
        slope_milli = SLOPE_BASE_MILLI + 11'(SLOPE_STEP_MILLI * {5'h00, code});
    endfunction : slope_milli

    function automatic logic reg_hit(input logic [5:0] idx);
        reg_hit = (idx >= IDX_LIMIT_SET && idx <= IDX_LIMIT_STAT) ||
                  (idx >= IDX_BOFS_SET && idx <= IDX_ESLP_STAT) ||
                  idx == IDX_IRQ_STATUS || idx == IDX_IRQ_MASK;
    endfunction : reg_hit

    // ****************************************************************
    // Bus slave
    // ****************************************************************
    logic        aw_full_q;
    logic [5:0]  aw_idx_q;
    logic        w_full_q;
    logic [7:0]  w_data_q;
    logic        w_lane_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;

    wire         aw_take  = I_AXI_AWVALID & O_AXI_AWREADY;
    wire         w_take   = I_AXI_WVALID & O_AXI_WREADY;
    wire         ar_take  = I_AXI_ARVALID & O_AXI_ARREADY;
    wire         do_write = aw_full_q & w_full_q & ~bvalid_q;
    wire         wr_en    = do_write & w_lane_q & reg_hit(aw_idx_q);
    wire [5:0]   ar_idx   = I_AXI_ARADDR[7:2];

    assign O_AXI_AWREADY = ~aw_full_q & ~bvalid_q;
    assign O_AXI_WREADY  = ~w_full_q & ~bvalid_q;
    assign O_AXI_ARREADY = ~rvalid_q;
    assign O_AXI_BVALID  = bvalid_q;
    assign O_AXI_BRESP   = bresp_q;
    assign O_AXI_RVALID  = rvalid_q;
    assign O_AXI_RDATA   = rdata_q;
    assign O_AXI_RRESP   = rresp_q;

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            aw_full_q <= 1'b0;
            aw_idx_q  <= 6'h00;
            w_full_q  <= 1'b0;
            w_data_q  <= 8'h00;
            w_lane_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_full_q <= 1'b1;
                aw_idx_q  <= I_AXI_AWADDR[7:2];
            end
            if (w_take) begin
                w_full_q <= 1'b1;
                w_data_q <= I_AXI_WDATA[7:0];
                w_lane_q <= I_AXI_WSTRB[0];
            end
            if (do_write) begin
                aw_full_q <= 1'b0;
                w_full_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= reg_hit(aw_idx_q) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_q && I_AXI_BREADY) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Setting registers
    // ****************************************************************
    logic [7:0] limit_set_q;
    logic [7:0] bofs_set_q;
    logic [7:0] eofs_set_q;
    logic [7:0] bslp_set_q;
    logic [7:0] eslp_set_q;
    logic [4:0] irq_mask_q;

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            limit_set_q <= RST_LIMIT_SET;
            bofs_set_q  <= RST_OFS_SET;
            eofs_set_q  <= RST_OFS_SET;
            bslp_set_q  <= RST_SLP_SET;
            eslp_set_q  <= RST_SLP_SET;
            irq_mask_q  <= RST_IRQ;
        end else if (wr_en) begin
            case (aw_idx_q)
                IDX_LIMIT_SET: limit_set_q <= w_data_q & WMASK_LIMIT;
                IDX_BOFS_SET:  bofs_set_q  <= w_data_q & WMASK_OFS;
                IDX_EOFS_SET:  eofs_set_q  <= w_data_q & WMASK_OFS;
                IDX_BSLP_SET:  bslp_set_q  <= w_data_q & WMASK_SLP;
                IDX_ESLP_SET:  eslp_set_q  <= w_data_q & WMASK_SLP;
                IDX_IRQ_MASK:  irq_mask_q  <= w_data_q[4:0];
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // Strap status and detection
    // ****************************************************************
    logic [7:0] limit_stat_q;
    logic [7:0] bofs_stat_q;
    logic [7:0] eofs_stat_q;
    logic [7:0] bslp_stat_q;
    logic [7:0] eslp_stat_q;
    logic [4:0] short_prev_q;
    logic [4:0] irq_status_q;

    wire [2:0] limit_field = I_EXT_LIMIT_STRAP.in_range ? I_EXT_LIMIT_STRAP.code : 3'h0;
    wire [7:0] limit_stat_d = {I_EXT_LIMIT_STRAP.shorted, limit_field, I_EXT_LIMIT_STRAP.open, 3'h0};
    wire [4:0] short_vec = {I_EXT_SLOPE_STRAP.shorted, I_BASIC_SLOPE_STRAP.shorted,
                            I_EXT_OFFSET_STRAP.shorted, I_BASIC_OFFSET_STRAP.shorted,
                            I_EXT_LIMIT_STRAP.shorted};
    wire [4:0] short_rise = short_vec & ~short_prev_q;
    wire       irq_clr    = wr_en && aw_idx_q == IDX_IRQ_STATUS;
    wire [4:0] irq_clr_bits = irq_clr ? w_data_q[4:0] : 5'h00;

    // Strap status tracks the pins each cycle; bus writes reach only the interrupt status
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            limit_stat_q <= RST_STAT;
            bofs_stat_q  <= RST_STAT;
            eofs_stat_q  <= RST_STAT;
            bslp_stat_q  <= RST_STAT;
            eslp_stat_q  <= RST_STAT;
            short_prev_q <= RST_IRQ;
            irq_status_q <= RST_IRQ;
        end else begin
            limit_stat_q <= limit_stat_d;
            bofs_stat_q  <= trim_status(I_BASIC_OFFSET_STRAP);
            eofs_stat_q  <= trim_status(I_EXT_OFFSET_STRAP);
            bslp_stat_q  <= trim_status(I_BASIC_SLOPE_STRAP);
            eslp_stat_q  <= trim_status(I_EXT_SLOPE_STRAP);
            short_prev_q <= short_vec;
            // A new short in the clearing cycle stays set
            irq_status_q <= (irq_status_q & ~irq_clr_bits) | short_rise;
        end
    end

    assign O_IRQ = |(irq_status_q & irq_mask_q);

    // ****************************************************************
    // Read path
    // ****************************************************************
    logic [7:0] rd_byte;
    always_comb begin
        case (ar_idx)
            IDX_LIMIT_SET:  rd_byte = limit_set_q;
            IDX_LIMIT_STAT: rd_byte = limit_stat_q;
            IDX_BOFS_SET:   rd_byte = bofs_set_q;
            IDX_BOFS_STAT:  rd_byte = bofs_stat_q;
            IDX_EOFS_SET:   rd_byte = eofs_set_q;
            IDX_EOFS_STAT:  rd_byte = eofs_stat_q;
            IDX_BSLP_SET:   rd_byte = bslp_set_q;
            IDX_BSLP_STAT:  rd_byte = bslp_stat_q;
            IDX_ESLP_SET:   rd_byte = eslp_set_q;
            IDX_ESLP_STAT:  rd_byte = eslp_stat_q;
            IDX_IRQ_STATUS: rd_byte = {3'h0, irq_status_q};
            IDX_IRQ_MASK:   rd_byte = {3'h0, irq_mask_q};
            default:        rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q  <= {24'h00_0000, rd_byte};
            rresp_q  <= reg_hit(ar_idx) ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && I_AXI_RREADY) begin
            rvalid_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Parameter selection
    // ****************************************************************
    wire         lim_use_reg = limit_set_q[OVERRIDE_BIT] | I_EXT_LIMIT_STRAP.open;
    wire [10:0]  lim_reg_ma  = LIMIT_BASE_MA + 11'(LIMIT_STEP_MA * {5'h00, limit_set_q[5:0]});
    wire [10:0]  lim_d       = lim_use_reg ? lim_reg_ma : strap_limit_ma(limit_field);

    // Profile picks which pair of pins and registers applies
    wire trim_strap_t ofs_strap = I_EXT_PROFILE ? I_EXT_OFFSET_STRAP : I_BASIC_OFFSET_STRAP;
    wire trim_strap_t slp_strap = I_EXT_PROFILE ? I_EXT_SLOPE_STRAP : I_BASIC_SLOPE_STRAP;
    wire [7:0]   ofs_set     = I_EXT_PROFILE ? eofs_set_q : bofs_set_q;
    wire [7:0]   slp_set     = I_EXT_PROFILE ? eslp_set_q : bslp_set_q;

    wire         ofs_use_reg = ofs_set[OVERRIDE_BIT] | ofs_strap.open;
    wire         slp_use_reg = slp_set[OVERRIDE_BIT] | slp_strap.open;
    wire [10:0]  ofs_mag     = 11'(OFS_STEP_MW * {6'h00, ofs_set[4:0]});
    wire signed [19:0] ofs_reg_mw = ofs_set[SIGN_BIT] ? -$signed({9'h000, ofs_mag})
                                                      : $signed({9'h000, ofs_mag});
    wire signed [19:0] ofs_mw = ofs_use_reg ? ofs_reg_mw : strap_offset_mw(ofs_strap.code, I_EXT_PROFILE);
    wire [10:0]  slp_milli   = slp_use_reg ? slope_milli(slp_set[5:0]) : slope_milli({2'b00, slp_strap.code});
    wire [26:0]  power_prod  = {11'h000, I_POWER_FUNC} * {16'h0000, slp_milli};
    wire [26:0]  power_scaled = power_prod / SLOPE_SCALE;
    // Quotient needs 18 bits at the largest register slope code
    wire signed [19:0] power_d = $signed({2'b00, power_scaled[17:0]}) + ofs_mw;

    // A short on any trim pin is a setting error
    wire trim_short  = |short_vec[EV_ESLP:EV_BOFS];
    wire ept_d       = trim_short | (I_EXT_LIMIT_STRAP.shorted & ~I_PMA_MODE);
    wire eoc_d       = I_EXT_LIMIT_STRAP.shorted & I_PMA_MODE;

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            O_CURRENT_LIMIT_MA <= 11'd0;
            O_RX_POWER_MW      <= 20'sd0;
            O_END_TRANSFER_REQ <= 1'b0;
            O_END_CHARGE_REQ   <= 1'b0;
        end else begin
            O_CURRENT_LIMIT_MA <= lim_d;
            O_RX_POWER_MW      <= power_d;
            O_END_TRANSFER_REQ <= ept_d;
            O_END_CHARGE_REQ   <= eoc_d;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RESET);

    property p_limit_override;
        limit_set_q[OVERRIDE_BIT] |=> O_CURRENT_LIMIT_MA == LIMIT_BASE_MA + 11'(LIMIT_STEP_MA * {5'h00, $past(limit_set_q[5:0])});
    endproperty
    a_limit_override: assert property (p_limit_override) else $error("limit ignores override");

    property p_limit_strap;
        !limit_set_q[OVERRIDE_BIT] && !I_EXT_LIMIT_STRAP.open && !I_EXT_LIMIT_STRAP.in_range
            |=> O_CURRENT_LIMIT_MA == 11'd500;
    endproperty
    a_limit_strap: assert property (p_limit_strap) else $error("out of range strap not 500 mA");

    property p_limit_short_req;
        I_EXT_LIMIT_STRAP.shorted |=> ($past(I_PMA_MODE) ? O_END_CHARGE_REQ : O_END_TRANSFER_REQ);
    endproperty
    a_limit_short_req: assert property (p_limit_short_req) else $error("limit short no request");

    property p_limit_short_mode;
        I_EXT_LIMIT_STRAP.shorted && I_PMA_MODE |=> O_END_CHARGE_REQ && limit_stat_q[SHORT_BIT];
    endproperty
    a_limit_short_mode: assert property (p_limit_short_mode) else $error("pma short no end of charge");

    property p_limit_open;
        I_EXT_LIMIT_STRAP.open |=> limit_stat_q[LIM_OPEN_BIT];
    endproperty
    a_limit_open: assert property (p_limit_open) else $error("open flag missing");

    property p_trim_short_ept;
        trim_short |=> O_END_TRANSFER_REQ;
    endproperty
    a_trim_short_ept: assert property (p_trim_short_ept) else $error("trim short no end transfer");

    property p_trim_forced;
        I_BASIC_SLOPE_STRAP.shorted |=> bslp_stat_q[6:3] == CODE_SHORTED && bslp_stat_q[SHORT_BIT];
    endproperty
    a_trim_forced: assert property (p_trim_forced) else $error("short code not forced");

    property p_trim_open;
        I_EXT_OFFSET_STRAP.open && !I_EXT_OFFSET_STRAP.shorted |=> eofs_stat_q[TRIM_OPEN_BIT] && eofs_stat_q[6:3] == CODE_OPEN;
    endproperty
    a_trim_open: assert property (p_trim_open) else $error("open status wrong");

    property p_power_offset;
        I_POWER_FUNC == 16'h0000 && I_EXT_PROFILE && eofs_set_q[OVERRIDE_BIT] && eofs_set_q[SIGN_BIT]
            |=> O_RX_POWER_MW == -$signed({15'h0000, $past(eofs_set_q[4:0])}) * 20'sd32;
    endproperty
    a_power_offset: assert property (p_power_offset) else $error("offset sign wrong");

    property p_irq_level;
        $rose(short_vec[EV_LIMIT]) |=> irq_status_q[EV_LIMIT] && (O_IRQ || !irq_mask_q[EV_LIMIT]);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

    c_override: cover property (wr_en && aw_idx_q == IDX_LIMIT_SET && w_data_q[OVERRIDE_BIT]);
    c_short_ept: cover property ($rose(O_END_TRANSFER_REQ));
    c_short_eoc: cover property ($rose(O_END_CHARGE_REQ));
    c_irq: cover property ($rose(O_IRQ));

endmodule : power_trim_config_select

/* testbench.sv */
`timescale 1ns/1ps
module testbench;
    import power_trim_pkg::*;
    logic         clk = 0, rst = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, ext = 0, pma = 0;
    logic [7:0]   awa = 0, ara = 0, wd = 0;
    logic [15:0]  pf = 0;
    limit_strap_t ls = '0;
    trim_strap_t  ts [4] = '{default: '0};
    logic [1:0]   bresp, rresp;
    logic         bv, rv, awr, wrd, arr, ept, eoc, irq;
    logic [31:0]  rdata, seed = 32'd17572;
    logic [10:0]  lim;
    logic signed [19:0] pw;
    logic [33:0]  exp_q [$];
    int           n_mismatch = 0, checks = 0, e;

    power_trim_config_select DUT (.I_CLK(clk), .I_RESET(rst), .I_AXI_AWADDR(awa), .I_AXI_AWVALID(awv),
        .O_AXI_AWREADY(awr), .I_AXI_WDATA({24'h0, wd}), .I_AXI_WSTRB(4'hF), .I_AXI_WVALID(wv),
        .O_AXI_WREADY(wrd), .O_AXI_BRESP(bresp), .O_AXI_BVALID(bv), .I_AXI_BREADY(br),
        .I_AXI_ARADDR(ara), .I_AXI_ARVALID(arv), .O_AXI_ARREADY(arr), .O_AXI_RDATA(rdata),
        .O_AXI_RRESP(rresp), .O_AXI_RVALID(rv), .I_AXI_RREADY(rr), .I_EXT_LIMIT_STRAP(ls),
        .I_BASIC_OFFSET_STRAP(ts[0]), .I_EXT_OFFSET_STRAP(ts[1]), .I_BASIC_SLOPE_STRAP(ts[2]),
        .I_EXT_SLOPE_STRAP(ts[3]), .I_EXT_PROFILE(ext), .I_PMA_MODE(pma), .I_POWER_FUNC(pf),
        .O_CURRENT_LIMIT_MA(lim), .O_RX_POWER_MW(pw), .O_END_TRANSFER_REQ(ept),
        .O_END_CHARGE_REQ(eoc), .O_IRQ(irq));

    initial forever #10 clk = ~clk;

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic report_and_stop;
        if (n_mismatch == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [33:0] g, input logic [33:0] x);
        checks++;
        if (g !== x) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask : chk

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask : tick

    // Hang guard: a bus that never answers ends the run as a failure
    task automatic hang(input int n);
        if (n >= 40) begin
            n_mismatch++;
            report_and_stop();
        end
    endtask : hang

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
        int n = 0;
        exp_q.push_back({r, 32'h0});
        @(posedge clk);
        awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awv && awr) awv <= 1'b0;
            if (wv && wrd) wv <= 1'b0;
        end while (!(bv && br) && n < 40);
        br <= 1'b0;
        hang(n);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
        int n = 0;
        exp_q.push_back({r, 24'h0, d});
        @(posedge clk);
        ara <= a; arv <= 1'b1; rr <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arv && arr) arv <= 1'b0;
        end while (!(rv && rr) && n < 40);
        rr <= 1'b0;
        hang(n);
    endtask : rd

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs

    // Responses are judged where they appear, against the oldest note
    always @(posedge clk) begin
        if (bv && br) chk({bresp, 32'h0}, exp_q.pop_front());
        if (rv && rr) chk({rresp, rdata}, exp_q.pop_front());
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        tick(20);
        rst <= 1'b0;
        rd(8'h20, 8'h11);
        rd(8'h24, 8'h00);
        rd(8'h9C, 8'h00);
        rd(8'hFC, 8'h00, RESP_SLVERR);
        ls <= '{1'b0, 1'b0, 1'b1, 3'h1};
        tick(3);
        chk(lim, 11'd700);
        rd(8'h24, 8'h10);
        ls.in_range <= 1'b0;
        rd(8'h24, 8'h00);
        wr(8'h20, 8'hCF);
        rd(8'h20, 8'h8F);
        chk(lim, 11'd1000);
        ls <= '{1'b0, 1'b1, 1'b0, 3'h0};
        wr(8'h20, 8'h09);
        tick(2);
        chk(lim, 11'd700);
        wr(8'h24, 8'hFF);
        rd(8'h24, 8'h08);
        wr(8'hC4, 8'h01);
        for (int m = 0; m < 2; m++) begin
            pma <= m[0];
            ls <= '{1'b1, 1'b0, 1'b0, 3'h0};
            tick(3);
            chk({ept, eoc, irq}, m ? 3'b011 : 3'b101);
            rd(8'h24, 8'h80);
            ls <= '0;
            wr(8'hC0, 8'h01);
            tick(2);
            chk({ept, eoc, irq}, 3'b000);
        end
        wr(8'hC4, 8'h00);
        for (int i = 0; i < 4; i++) begin
            ts[i] <= '{1'b1, 1'b0, 4'h3};
            tick(3);
            chk({ept, irq}, 2'b10);
            rd(8'h84 + 8'(8 * i), 8'hF8);
            ts[i] <= '{1'b0, 1'b1, 4'h0};
            rd(8'h84 + 8'(8 * i), 8'h04);
        end
        rd(8'hC0, 8'h1E);
        wr(8'hC0, 8'h1E);
        rd(8'hC0, 8'h00);
        wr(8'h80, 8'h43);
        wr(8'h88, 8'h05);
        wr(8'h90, 8'h01);
        wr(8'h98, 8'h0E);
        for (int k = 0; k < 6; k++) begin
            seed = xs(seed);
            pf <= seed[15:0];
            ext <= k[0];
            e = k[0] ? int'(seed[15:0]) * 1262 / 1000 + 160 : int'(seed[15:0]) * 1054 / 1000 - 96;
            tick(3);
            chk({14'h0, pw}, {14'h0, 20'(e)});
        end
        // Strap path once the pins carry valid resistors
        pf <= 16'd1000;
        ts <= '{'{1'b0, 1'b0, 4'h4}, '{1'b0, 1'b0, 4'h5}, '{1'b0, 1'b0, 4'h1}, '{1'b0, 1'b0, 4'hE}};
        tick(3);
        chk({14'h0, pw}, {14'h0, 20'd1422});
        ext <= 1'b0;
        tick(3);
        chk({14'h0, pw}, {14'h0, 20'd1118});
        wr(8'h80, 8'hC3);
        tick(2);
        chk({14'h0, pw}, {14'h0, 20'd958});
        pf <= 16'h0000;
        ext <= 1'b1;
        wr(8'h88, 8'hC5);
        tick(2);
        chk({14'h0, pw}, {14'h0, -20'sd160});
        tick(2);
        report_and_stop();
    end
endmodule : testbench
